// ==== logic/brs_seq.sv ====
// bar code read-mode sequencer: trigger window, acceptance, ok/fail, records
//
// Function
// - four read modes: single, sequential, batched, typed per slot.
// - single mode accepts and reports one label per trigger window.
// - sequential mode sends each accepted label at once, one record each.
// - sequential and batched modes lock out repeated content for 100 ms to 25.5 s.
// - sequential mode sends an error record only if the window read nothing.
// - sequential mode pulses ok per label, fail on empty window, no comparison.
// - batched mode buffers labels and sends one record at window close.
// - batched mode: ok if any label read, fail otherwise, at close.
// - fields in a record are separated by comma 2ch.
// - batched record field count equals labels read, capped by buffer size.
// - typed mode reads up to 4 labels, only configured slots take part.
// - typed mode accepts any order, sends by slot order after close.
// - typed mode: ok only if every configured slot read, else fail.
// - typed mode puts error text in place of missing slot data.
// - four identical slot types fill the record in arrival order.
// - typed mode rejects content already accepted in this window.
// - orientation filter accepts only set direction, wrong one is a read error.
// - with orientation filter off both directions are accepted.
// - orientation filter works in all modes, direction held per slot.
// - one-shot trigger opens on rising edge for the preset input time.
// - multi-label modes always send after read; release timing single only.
`timescale 1ns/100ps
`default_nettype none
`include "brs_params.svh"
module brs_seq #(
   parameter int unsigned MS_CYCLES = `BRS_MS_CYCLES
) (
   // clock and reset
   input  wire logic             ref_clk_i,
   input  wire logic             rst_n_i,
   // trigger and configuration
   input  wire logic             read_trigger_input_i,
   input  wire logic [1:0]       cfg_read_mode_i,
   input  wire logic             cfg_one_shot_i,
   input  wire logic [15:0]      cfg_preset_ms_i,
   input  wire logic             cfg_send_at_release_i,
   input  wire logic [7:0]       cfg_lockout_i,
   input  wire logic             cfg_orient_en_i,
   input  wire logic [3:0]       cfg_orient_rev_i,
   input  wire logic [3:0][3:0]  cfg_slot_type_i,
   input  wire logic [3:0][5:0]  cfg_slot_len_i,
   // decoder
   input  wire logic             dec_valid_i,
   input  wire logic [31:0]      dec_data_i,
   input  wire logic [3:0]       dec_type_i,
   input  wire logic [5:0]       dec_len_i,
   input  wire logic             dec_rev_i,
   output var  logic             dec_ready_o,
   // results
   output var  logic             result_ok_o,
   output var  logic             result_fail_output_o,
   output var  logic             window_open_o,
   // serial byte stream
   output var  logic             tx_valid_o,
   output var  logic [7:0]       tx_data_o,
   input  wire logic             tx_ready_i
);
   brs_rec_if rec ();

   brs_pkg::brs_win_t  win;
   brs_pkg::brs_mode_t mode;
   logic               trig_q;
   logic               one_shot;
   logic               at_release;
   logic [15:0]        preset_ms;
   logic [7:0]         lockout;
   logic               orient_en;
   logic [3:0]         orient_rev;
   logic [3:0][3:0]    slot_type;
   logic [3:0][5:0]    slot_len;
   logic [31:0]        tick_cnt;
   logic               ms_tick;
   logic [15:0]        win_ms;
   logic [3:0][31:0]   buf_data;
   logic [3:0]         filled;
   logic [2:0]         count;
   logic [3:0][31:0]   lock_data;
   logic [3:0][14:0]   lock_ms;
   logic [1:0]         lock_ptr;
   logic               rec_start;
   logic [3:0]         rec_use;
   logic [3:0]         rec_err;

   // label content found in a list of valid entries
   function automatic logic in_list(input logic [3:0][31:0] d, input logic [3:0] v,
                                    input logic [31:0] x);
      logic hit;
      hit = 1'b0;
      for (int i = 0; i < `BRS_SLOTS; i++) begin
         if (v[i] && d[i] == x) begin
            hit = 1'b1;
         end
      end
      return hit;
   endfunction : in_list

   // first slot whose type and length match and is in the allowed mask
   function automatic logic [2:0] find_slot(input logic [3:0][3:0] t,
                                            input logic [3:0][5:0] l,
                                            input logic [3:0] allow,
                                            input logic [3:0] ty, input logic [5:0] ln);
      logic [2:0] r;
      r = 3'h4;
      for (int i = 3; i >= 0; i--) begin
         if (allow[i] && t[i] != 4'h0 && t[i] == ty && l[i] == ln) begin
            r = 3'(i);
         end
      end
      return r;
   endfunction : find_slot

   logic       trig_rise;
   logic       close_now;
   logic [3:0] cfg_mask;
   logic       all_same;
   logic [2:0] type_slot;
   logic [2:0] dest;
   logic [1:0] orient_idx;
   logic       dir_ok;
   logic       locked;
   logic       take;
   logic       accept;
   logic       dir_fail;
   logic [3:0] lock_valid;
   logic       launch;

   always_comb begin
      for (int i = 0; i < `BRS_SLOTS; i++) begin
         cfg_mask[i]   = (slot_type[i] != 4'h0);
         lock_valid[i] = (lock_ms[i] != 15'h0);
      end
   end

   assign trig_rise = read_trigger_input_i & ~trig_q;
   // one-shot window runs the preset time, level window follows the trigger
   assign close_now = one_shot ? (ms_tick && win_ms + 16'h1 >= preset_ms)
                               : ~read_trigger_input_i;
   assign all_same  = (cfg_mask == 4'hf) && (slot_type[1] == slot_type[0])
                    && (slot_type[2] == slot_type[0]) && (slot_type[3] == slot_type[0])
                    && (slot_len[1] == slot_len[0]) && (slot_len[2] == slot_len[0])
                    && (slot_len[3] == slot_len[0]);
   assign type_slot = find_slot(slot_type, slot_len, ~filled, dec_type_i, dec_len_i);
   // arrival order when all slots alike, else by matching slot
   assign dest      = all_same ? count : type_slot;
   // no matching slot gives code 4, whose low bits pick slot 0
   assign orient_idx = 2'(find_slot(slot_type, slot_len, 4'hf, dec_type_i, dec_len_i));
   assign dir_ok    = ~orient_en | (dec_rev_i == orient_rev[orient_idx]);
   assign locked    = in_list(lock_data, lock_valid, dec_data_i);
   assign take      = dec_valid_i & dec_ready_o & ~rec.busy & ~rec_start
                    & (win == brs_pkg::BRS_WIN_OPEN);
   assign dir_fail  = take & ~dir_ok;
   assign launch    = accept && (mode == brs_pkg::BRS_MODE_SEQ
                    || (mode == brs_pkg::BRS_MODE_SINGLE && !at_release));

   always_comb begin
      accept = 1'b0;
      if (take && dir_ok) begin
         unique case (mode)
            brs_pkg::BRS_MODE_SINGLE: accept = (count == 3'h0);
            brs_pkg::BRS_MODE_SEQ:    accept = ~locked;
            brs_pkg::BRS_MODE_BATCH:  accept = ~locked && count < 3'(`BRS_SLOTS);
            brs_pkg::BRS_MODE_TYPED:  accept = dest != 3'h4 && count < 3'(`BRS_SLOTS)
                                             && ~in_list(buf_data, filled, dec_data_i);
         endcase
      end
   end

   // millisecond tick, shared by preset time and lockout timers
   always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         tick_cnt <= 32'h0;
         ms_tick  <= 1'b0;
      end else begin
         ms_tick  <= (tick_cnt == 32'(MS_CYCLES - 1));
         tick_cnt <= (tick_cnt == 32'(MS_CYCLES - 1)) ? 32'h0 : tick_cnt + 32'h1;
      end
   end

   // configuration snapshot at window open
   always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         mode       <= brs_pkg::BRS_MODE_SINGLE;
         one_shot   <= 1'b0;
         at_release <= 1'b0;
         preset_ms  <= 16'h0;
         lockout    <= `BRS_LOCK_MIN;
         orient_en  <= 1'b0;
         orient_rev <= 4'h0;
         slot_type  <= '0;
         slot_len   <= '0;
      end else if (win == brs_pkg::BRS_WIN_IDLE) begin
         mode       <= brs_pkg::brs_mode_t'(cfg_read_mode_i);
         one_shot   <= cfg_one_shot_i;
         // release timing only for single mode
         at_release <= cfg_send_at_release_i
                     & (cfg_read_mode_i == brs_pkg::BRS_MODE_SINGLE);
         preset_ms  <= cfg_preset_ms_i;
         lockout    <= (cfg_lockout_i == 8'h0) ? `BRS_LOCK_MIN : cfg_lockout_i;
         orient_en  <= cfg_orient_en_i;
         orient_rev <= cfg_orient_rev_i;
         slot_type  <= cfg_slot_type_i;
         slot_len   <= cfg_slot_len_i;
      end
   end

   // window state
   always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         win    <= brs_pkg::BRS_WIN_IDLE;
         trig_q <= 1'b0;
         win_ms <= 16'h0;
      end else begin
         trig_q <= read_trigger_input_i;
         unique case (win)
            brs_pkg::BRS_WIN_IDLE: begin
               win_ms <= 16'h0;
               if (cfg_one_shot_i ? trig_rise : read_trigger_input_i) begin
                  win <= brs_pkg::BRS_WIN_OPEN;
               end
            end
            brs_pkg::BRS_WIN_OPEN: begin
               if (ms_tick) begin
                  win_ms <= win_ms + 16'h1;
               end
               if (close_now && !rec.busy && !rec_start) begin
                  win <= brs_pkg::BRS_WIN_SEND;
               end
            end
            brs_pkg::BRS_WIN_SEND: win <= brs_pkg::BRS_WIN_IDLE;
            default:               win <= brs_pkg::BRS_WIN_IDLE;
         endcase
      end
   end

   // label buffer, one entry per slot
   always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         buf_data <= '0;
         filled   <= 4'h0;
         count    <= 3'h0;
      end else if (win == brs_pkg::BRS_WIN_IDLE) begin
         filled <= 4'h0;
         count  <= 3'h0;
      end else if (accept) begin
         count <= count + 3'h1;
         if (mode == brs_pkg::BRS_MODE_TYPED) begin
            buf_data[dest[1:0]] <= dec_data_i;
            filled[dest[1:0]]   <= 1'b1;
         end else if (mode == brs_pkg::BRS_MODE_BATCH) begin
            buf_data[count[1:0]] <= dec_data_i;
            filled[count[1:0]]   <= 1'b1;
         end else begin
            buf_data[0] <= dec_data_i;
            filled[0]   <= 1'b1;
         end
      end
   end

   // repeat-read lockout table, timers count whole milliseconds
   always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         lock_data <= '0;
         lock_ms   <= '0;
         lock_ptr  <= 2'h0;
      end else begin
         for (int i = 0; i < `BRS_SLOTS; i++) begin
            if (ms_tick && lock_ms[i] != 15'h0) begin
               lock_ms[i] <= lock_ms[i] - 15'h1;
            end
         end
         if (accept && (mode == brs_pkg::BRS_MODE_SEQ || mode == brs_pkg::BRS_MODE_BATCH)) begin
            lock_data[lock_ptr] <= dec_data_i;
            lock_ms[lock_ptr]   <= 15'(lockout * `BRS_LOCK_UNIT_MS);
            lock_ptr            <= lock_ptr + 2'h1;
         end
      end
   end

   // record launch and result pulses
   always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         rec_start            <= 1'b0;
         rec_use              <= 4'h0;
         rec_err              <= 4'h0;
         result_ok_o          <= 1'b0;
         result_fail_output_o <= 1'b0;
      end else begin
         rec_start            <= 1'b0;
         result_ok_o          <= 1'b0;
         result_fail_output_o <= dir_fail;
         if (launch) begin
            rec_start   <= 1'b1;
            rec_use     <= 4'h1;
            rec_err     <= 4'h0;
            result_ok_o <= 1'b1;
         end
         if (win == brs_pkg::BRS_WIN_SEND) begin
            unique case (mode)
               brs_pkg::BRS_MODE_SINGLE, brs_pkg::BRS_MODE_SEQ: begin
                  if (count == 3'h0) begin
                     rec_start            <= 1'b1;
                     rec_use              <= 4'h1;
                     rec_err              <= 4'h1;
                     result_fail_output_o <= 1'b1;
                  end else if (at_release) begin
                     rec_start   <= 1'b1;
                     rec_use     <= 4'h1;
                     rec_err     <= 4'h0;
                     result_ok_o <= 1'b1;
                  end
               end
               brs_pkg::BRS_MODE_BATCH: begin
                  rec_start            <= 1'b1;
                  rec_use              <= (count == 3'h0) ? 4'h1 : filled;
                  rec_err              <= (count == 3'h0) ? 4'h1 : 4'h0;
                  result_ok_o          <= (count != 3'h0);
                  result_fail_output_o <= (count == 3'h0);
               end
               brs_pkg::BRS_MODE_TYPED: begin
                  rec_start            <= 1'b1;
                  rec_use              <= cfg_mask;
                  rec_err              <= cfg_mask & ~filled;
                  result_ok_o          <= ((cfg_mask & ~filled) == 4'h0);
                  result_fail_output_o <= ((cfg_mask & ~filled) != 4'h0);
               end
            endcase
         end
      end
   end

   // decoder may hand a label only while a window is open and no record pending
   always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         dec_ready_o   <= 1'b0;
         window_open_o <= 1'b0;
      end else begin
         // low ahead of a record launch, so ready never shows while a take is blocked
         dec_ready_o   <= (win == brs_pkg::BRS_WIN_OPEN) && !close_now && !rec.busy
                          && !rec_start && !launch;
         window_open_o <= (win == brs_pkg::BRS_WIN_OPEN);
      end
   end

   assign rec.start    = rec_start;
   assign rec.use_mask = rec_use;
   assign rec.err_mask = rec_err;
   assign rec.fields   = buf_data;

   brs_rec_fmt u_fmt (
      .ref_clk_i  (ref_clk_i),
      .rst_n_i    (rst_n_i),
      .rec        (rec),
      .tx_valid_o (tx_valid_o),
      .tx_data_o  (tx_data_o),
      .tx_ready_i (tx_ready_i)
   );
endmodule : brs_seq
`default_nettype wire

// ==== logic/brs_params.svh ====
// brs read-mode sequencer constants: characters, timing and sizes
`ifndef BRS_PARAMS_SVH
`define BRS_PARAMS_SVH

`define BRS_SLOTS        4
`define BRS_FIELD_BYTES  4
`define BRS_CHAR_COMMA   8'h2c
`define BRS_CHAR_HDR     8'h02
`define BRS_CHAR_DLM     8'h0d
`define BRS_ERR_LEN      5
`define BRS_CLK_NS       20
`define BRS_MS_NS        1000000
`define BRS_MS_CYCLES    (`BRS_MS_NS / `BRS_CLK_NS)
`define BRS_LOCK_UNIT_MS 100
`define BRS_LOCK_MIN     8'h01

`endif

// ==== logic/brs_pkg.sv ====
// brs read-mode sequencer types
package brs_pkg;

   typedef enum logic [1:0] {
      BRS_MODE_SINGLE = 2'b00,
      BRS_MODE_SEQ    = 2'b01,
      BRS_MODE_BATCH  = 2'b10,
      BRS_MODE_TYPED  = 2'b11
   } brs_mode_t;

   typedef enum logic [1:0] {
      BRS_WIN_IDLE = 2'b00,
      BRS_WIN_OPEN = 2'b01,
      BRS_WIN_SEND = 2'b10
   } brs_win_t;

   typedef enum logic [1:0] {
      BRS_FMT_IDLE = 2'b00,
      BRS_FMT_HDR  = 2'b01,
      BRS_FMT_FLD  = 2'b10
   } brs_fmt_t;

endpackage : brs_pkg

// ==== logic/brs_rec_if.sv ====
// record hand-off between sequencer and formatter
`timescale 1ns/100ps
`default_nettype none
interface brs_rec_if;
   logic              start;
   logic [3:0]        use_mask;
   logic [3:0]        err_mask;
   logic [3:0][31:0]  fields;
   logic              busy;

   modport producer (output start, use_mask, err_mask, fields, input busy);
   modport consumer (input start, use_mask, err_mask, fields, output busy);
endinterface : brs_rec_if
`default_nettype wire

// ==== logic/brs_rec_fmt.sv ====
// record formatter: header, comma separated fields, delimiter
`timescale 1ns/100ps
`default_nettype none
`include "brs_params.svh"
module brs_rec_fmt (
   // clock and reset
   input  wire logic      ref_clk_i,
   input  wire logic      rst_n_i,
   // record from sequencer
   brs_rec_if.consumer    rec,
   // byte stream out
   output var  logic      tx_valid_o,
   output var  logic [7:0] tx_data_o,
   input  wire logic      tx_ready_i
);
   brs_pkg::brs_fmt_t st;
   logic [3:0]        rem;
   logic [3:0]        errs;
   logic [3:0][31:0]  flds;
   logic [2:0]        bi;
   logic              comma_due;
   logic [1:0]        slot;

   function automatic logic [1:0] low_set(input logic [3:0] m);
      logic [1:0] r;
      r = 2'h0;
      for (int i = 3; i >= 0; i--) begin
         if (m[i]) begin
            r = 2'(i);
         end
      end
      return r;
   endfunction : low_set

   function automatic logic [7:0] err_char(input logic [2:0] i);
      logic [7:0] c;
      unique case (i)
         3'h1, 3'h2, 3'h4: c = 8'h52;
         3'h3:             c = 8'h4f;
         default:          c = 8'h45;
      endcase
      return c;
   endfunction : err_char

   assign slot     = low_set(rem);
   assign rec.busy = (st != brs_pkg::BRS_FMT_IDLE) | tx_valid_o;

   always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         st         <= brs_pkg::BRS_FMT_IDLE;
         rem        <= 4'h0;
         errs       <= 4'h0;
         flds       <= '0;
         bi         <= 3'h0;
         comma_due  <= 1'b0;
         tx_valid_o <= 1'b0;
         tx_data_o  <= 8'h00;
      end else if (!tx_valid_o || tx_ready_i) begin
         tx_valid_o <= 1'b0;
         unique case (st)
            brs_pkg::BRS_FMT_IDLE: begin
               if (rec.start) begin
                  rem  <= rec.use_mask;
                  errs <= rec.err_mask;
                  flds <= rec.fields;
                  st   <= brs_pkg::BRS_FMT_HDR;
               end
            end
            brs_pkg::BRS_FMT_HDR: begin
               tx_valid_o <= 1'b1;
               tx_data_o  <= `BRS_CHAR_HDR;
               bi         <= 3'h0;
               comma_due  <= 1'b0;
               st         <= brs_pkg::BRS_FMT_FLD;
            end
            brs_pkg::BRS_FMT_FLD: begin
               tx_valid_o <= 1'b1;
               if (rem == 4'h0) begin
                  tx_data_o <= `BRS_CHAR_DLM;
                  st        <= brs_pkg::BRS_FMT_IDLE;
               end else if (comma_due) begin
                  tx_data_o <= `BRS_CHAR_COMMA;
                  comma_due <= 1'b0;
               end else if (errs[slot]) begin
                  tx_data_o <= err_char(bi);
                  if (bi == 3'(`BRS_ERR_LEN - 1)) begin
                     rem[slot] <= 1'b0;
                     bi        <= 3'h0;
                     comma_due <= 1'b1;
                  end else begin
                     bi <= bi + 3'h1;
                  end
               end else begin
                  tx_data_o <= flds[slot][8'(31 - 8 * bi) -: 8];
                  if (bi == 3'(`BRS_FIELD_BYTES - 1)) begin
                     rem[slot] <= 1'b0;
                     bi        <= 3'h0;
                     comma_due <= 1'b1;
                  end else begin
                     bi <= bi + 3'h1;
                  end
               end
            end
            default: st <= brs_pkg::BRS_FMT_IDLE;
         endcase
      end
   end
endmodule : brs_rec_fmt
`default_nettype wire

// ==== verif/brs_host_model.sv ====
// host serial sink answering promptly or slowly
`timescale 1ns/100ps
`default_nettype none
module brs_host_model (
   // clock and pace
   input  wire logic ref_clk_i,
   input  wire logic slow_i,
   // byte stream
   output var  logic tx_ready_o
);
   logic [1:0] cnt;
   initial cnt = 2'h0;
   initial tx_ready_o = 1'b0;
   // slow pace takes one byte in four
   always @(negedge ref_clk_i) begin
      cnt <= cnt + 2'h1;
      tx_ready_o <= !slow_i || cnt == 2'h3;
   end
endmodule : brs_host_model
`default_nettype wire

// ==== verif/brs_seq_asserts.sv ====
// port assertions for the read-mode sequencer
`timescale 1ns/100ps
`default_nettype none
module brs_seq_asserts (
   // clock, reset, inputs
   input wire logic       ref_clk_i,
   input wire logic       rst_n_i,
   input wire logic       read_trigger_input_i,
   input wire logic       cfg_one_shot_i,
   input wire logic       cfg_orient_en_i,
   input wire logic [3:0] cfg_orient_rev_i,
   input wire logic       dec_valid_i,
   input wire logic       dec_rev_i,
   input wire logic       tx_ready_i,
   // outputs
   input wire logic       dec_ready_o,
   input wire logic       result_ok_o,
   input wire logic       result_fail_output_o,
   input wire logic       window_open_o,
   input wire logic       tx_valid_o,
   input wire logic [7:0] tx_data_o
);
   default clocking cb @(posedge ref_clk_i); endclocking
   default disable iff (!rst_n_i);
   sequence take_s; dec_valid_i && dec_ready_o; endsequence
   sequence hdr_s; tx_valid_o && tx_data_o == 8'h02; endsequence
   ok_fail_excl_a: assert property (!(result_ok_o && result_fail_output_o))
      else $error("ok and fail together");
   ok_pulse_a: assert property (result_ok_o |=> !result_ok_o)
      else $error("ok pulse too long");
   fail_pulse_a: assert property (result_fail_output_o |=> !result_fail_output_o)
      else $error("fail pulse too long");
   tx_hold_a: assert property (tx_valid_o && !tx_ready_i |=> tx_valid_o && $stable(tx_data_o))
      else $error("byte dropped before taken");
   win_trig_a: assert property ($rose(window_open_o) |-> $past(read_trigger_input_i))
      else $error("window opened without trigger");
   closed_refuse_a: assert property (!window_open_o && !$past(window_open_o) |-> !dec_ready_o)
      else $error("label taken while closed");
   busy_refuse_a: assert property (tx_valid_o |-> !dec_ready_o)
      else $error("label taken while sending");
   ok_record_a: assert property (result_ok_o |-> ##[0:8] hdr_s)
      else $error("no record after ok");
   win_close_a: assert property (window_open_o && !read_trigger_input_i && !cfg_one_shot_i
      |-> ##[1:400] !window_open_o)
      else $error("window did not close");
   orient_fail_a: assert property (take_s ##0 (cfg_orient_en_i && cfg_orient_rev_i == 4'h0
      && dec_rev_i) |-> ##[1:3] result_fail_output_o)
      else $error("wrong direction not failed");
endmodule : brs_seq_asserts
bind brs_seq brs_seq_asserts u_asserts (.ref_clk_i, .rst_n_i, .read_trigger_input_i,
   .cfg_one_shot_i, .cfg_orient_en_i, .cfg_orient_rev_i, .dec_valid_i, .dec_rev_i,
   .tx_ready_i, .dec_ready_o, .result_ok_o, .result_fail_output_o, .window_open_o,
   .tx_valid_o, .tx_data_o);
`default_nettype wire

// ==== verif/brs_seq_tb.sv ====
// self-checking bench for the read-mode sequencer
`timescale 1ns/100ps
`default_nettype none
module brs_seq_tb;
   typedef struct {logic [31:0] d; logic [3:0] t; logic r;} brs_lab_t;
   logic            ref_clk_i = 1'b0;
   logic            rst_n_i = 1'b0;
   logic            trig = 1'b0;
   logic [1:0]      mode = 2'h0;
   logic            os = 1'b0;
   logic            rel = 1'b0;
   logic            oen = 1'b0;
   logic [3:0][3:0] sty = {4'h3, 4'h0, 4'h2, 4'h1};
   logic            dv = 1'b0;
   logic [31:0]     dd = 32'h0;
   logic [3:0]      dt = 4'h1;
   logic            dr = 1'b0;
   logic            slow = 1'b0;
   logic            dec_ready, ok, fail, win, tx_valid, tx_ready;
   logic [7:0]      tx_data;
   logic [15:0]     lfsr = 16'h31fd;
   logic [15:0]     pms = 16'h0005;
   logic [7:0]      lko = 8'h01;
   logic [3:0]      orev = 4'h0;
   logic [31:0]     v[20];
   logic [7:0]      rx[$], ex[$];
   brs_lab_t        lq[$];
   int              mismatches = 0, comparisons = 0, oks = 0, fails = 0;
   brs_seq #(.MS_CYCLES(10)) dut (.ref_clk_i, .rst_n_i, .read_trigger_input_i(trig),
      .cfg_read_mode_i(mode), .cfg_one_shot_i(os), .cfg_preset_ms_i(pms),
      .cfg_send_at_release_i(rel), .cfg_lockout_i(lko), .cfg_orient_en_i(oen),
      .cfg_orient_rev_i(orev), .cfg_slot_type_i(sty), .cfg_slot_len_i({4{6'h08}}),
      .dec_valid_i(dv), .dec_data_i(dd), .dec_type_i(dt), .dec_len_i(6'h08),
      .dec_rev_i(dr), .dec_ready_o(dec_ready), .result_ok_o(ok),
      .result_fail_output_o(fail), .window_open_o(win), .tx_valid_o(tx_valid),
      .tx_data_o(tx_data), .tx_ready_i(tx_ready));
   brs_host_model host (.ref_clk_i, .slow_i(slow), .tx_ready_o(tx_ready));
   initial forever #10 ref_clk_i = ~ref_clk_i;
   always @(posedge ref_clk_i) begin
      if (ok === 1'b1) oks++;
      if (fail === 1'b1) fails++;
      if (tx_valid === 1'b1 && tx_ready === 1'b1) rx.push_back(tx_data);
   end
   function automatic logic [31:0] rnd();
      lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
      return {lfsr, ~lfsr};
   endfunction : rnd
   function automatic void fld(input logic [31:0] d, input logic e);
      if (ex[$] !== 8'h02) ex.push_back(8'h2c);
      if (e) ex = {ex, 8'h45, 8'h52, 8'h52, 8'h4f, 8'h52};
      else ex = {ex, d[31:24], d[23:16], d[15:8], d[7:0]};
   endfunction : fld
   function automatic void rec1(input logic [31:0] d);
      ex.push_back(8'h02);
      fld(d, 1'b0);
      ex.push_back(8'h0d);
   endfunction : rec1
   function automatic void qa(input logic [31:0] d, input logic [3:0] t, input logic r);
      lq.push_back('{d, t, r});
   endfunction : qa
   task automatic err(input string m);
      mismatches++;
      $display("Error at %0t: %s", $time, m);
   endtask : err
   task automatic chk(input logic c, input string m);
      comparisons++;
      if (c !== 1'b1) err(m);
   endtask : chk
   task automatic lab(input brs_lab_t l);
      int n;
      @(negedge ref_clk_i);
      dd = l.d;
      dt = l.t;
      dr = l.r;
      dv = 1'b1;
      for (n = 0; dec_ready !== 1'b1 && n < 400; n++) @(negedge ref_clk_i);
      @(negedge ref_clk_i);
      dv = 1'b0;
      chk(n < 400, "label not taken");
   endtask : lab
   task automatic run(input logic [1:0] m, input logic s, input int okx, input int flx);
      int n;
      mode = m;
      os = s;
      @(negedge ref_clk_i);
      oks = 0;
      fails = 0;
      rx = {};
      trig = 1'b1;
      for (n = 0; win !== 1'b1 && n < 50; n++) @(negedge ref_clk_i);
      if (s) trig = 1'b0;
      foreach (lq[i]) lab(lq[i]);
      trig = 1'b0;
      for (n = 0; win !== 1'b0 && n < 1000; n++) @(negedge ref_clk_i);
      repeat (120) @(negedge ref_clk_i);
      chk(rx.size() == ex.size(), "record length");
      foreach (ex[i]) chk(i < rx.size() && rx[i] === ex[i], "record byte");
      chk(oks == okx && fails == flx, "ok or fail count");
      lq = {};
      ex = {};
   endtask : run
   task final_report;
      $display("comparisons %0d mismatches %0d", comparisons, mismatches);
      if (mismatches == 0 && comparisons > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask : final_report
   initial begin
      #(20 * 60000);
      err("watchdog");
      final_report();
   end
   initial begin
      foreach (v[i]) v[i] = rnd();
      repeat (20) @(negedge ref_clk_i);
      rst_n_i = 1'b1;
      // sequential: repeat locked, wrong direction failed, release option ignored
      oen = 1'b1;
      rel = 1'b1;
      qa(v[1], 4'h1, 1'b0); qa(v[1], 4'h1, 1'b0); qa(v[2], 4'h1, 1'b1); qa(v[3], 4'h1, 1'b0);
      rec1(v[1]); rec1(v[3]);
      run(brs_pkg::BRS_MODE_SEQ, 1'b0, 2, 1);
      oen = 1'b0;
      rel = 1'b0;
      slow = 1'b1;
      // batched: both directions, repeat locked, buffer full at four
      qa(v[4], 4'h1, 1'b1); qa(v[4], 4'h1, 1'b0);
      for (int i = 5; i < 9; i++) qa(v[i], 4'h1, 1'b0);
      ex.push_back(8'h02);
      for (int i = 4; i < 8; i++) fld(v[i], 1'b0);
      ex.push_back(8'h0d);
      run(brs_pkg::BRS_MODE_BATCH, 1'b0, 1, 0);
      ex = {8'h02}; fld(32'h0, 1'b1); ex.push_back(8'h0d);
      run(brs_pkg::BRS_MODE_BATCH, 1'b0, 0, 1);
      slow = 1'b0;
      // typed: out of order, duplicate content refused, missing slot as error
      qa(v[9], 4'h3, 1'b0); qa(v[10], 4'h1, 1'b0); qa(v[10], 4'h2, 1'b0);
      ex = {8'h02}; fld(v[10], 1'b0); fld(32'h0, 1'b1); fld(v[9], 1'b0); ex.push_back(8'h0d);
      run(brs_pkg::BRS_MODE_TYPED, 1'b0, 0, 1);
      sty = {4{4'h1}};
      ex = {8'h02};
      for (int i = 14; i > 10; i--) qa(v[i], 4'h1, 1'b0);
      for (int i = 14; i > 10; i--) fld(v[i], 1'b0);
      ex.push_back(8'h0d);
      run(brs_pkg::BRS_MODE_TYPED, 1'b0, 1, 0);
      qa(v[15], 4'h1, 1'b0); qa(v[16], 4'h1, 1'b0); rec1(v[15]);
      run(brs_pkg::BRS_MODE_SINGLE, 1'b0, 1, 0);
      qa(v[17], 4'h1, 1'b0); rec1(v[17]);
      run(brs_pkg::BRS_MODE_BATCH, 1'b1, 1, 0);
      final_report();
   end
endmodule : brs_seq_tb
`default_nettype wire
